// ==== design/dpalu_core.sv ====
// Purpose: data-processing instruction execute stage
// Assumes: operands arrive in the cycle of instr_valid
// Notes: results and flags show one cycle later
`timescale 1ns/1ns
module dpalu_core #(
  parameter int CNT_W = 16
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic instr_valid,
  input wire logic [31:0] instr_word,
  input wire logic [31:0] first_operand,
  input wire logic [31:0] shifted_operand,
  input wire logic shifter_carry,
  input wire logic [31:0] saved_status_word,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  output logic result_valid,
  output logic [31:0] result_data,
  output logic dest_write,
  output logic [3:0] dest_index,
  output logic pc_write,
  output logic status_restored,
  output logic [31:0] program_status_word
);
  typedef struct packed {
    logic [31:0] psw;
    logic [31:0] res;
    logic [31:0] rdata;
    logic [CNT_W-1:0] cnt;
    logic [3:0] didx;
    logic rvalid;
    logic dwe;
    logic pcwe;
    logic rest;
    logic fupd;
  } dpalu_state_t;

  dpalu_state_t st;
  dpalu_state_t next_st;

  // --------------------------------------------------
  // Decode helpers
  // --------------------------------------------------
  // Predicate test against flags n z c v
  function automatic logic dpalu_pass(input logic [3:0] c,
                                      input logic [3:0] f);
    logic n, z, cy, v;
    n = f[3];
    z = f[2];
    cy = f[1];
    v = f[0];
    unique case (c)
      4'h0: dpalu_pass = z;
      4'h1: dpalu_pass = !z;
      4'h2: dpalu_pass = cy;
      4'h3: dpalu_pass = !cy;
      4'h4: dpalu_pass = n;
      4'h5: dpalu_pass = !n;
      4'h6: dpalu_pass = v;
      4'h7: dpalu_pass = !v;
      4'h8: dpalu_pass = cy && !z;
      4'h9: dpalu_pass = !cy || z;
      4'hA: dpalu_pass = n == v;
      4'hB: dpalu_pass = n != v;
      4'hC: dpalu_pass = !z && (n == v);
      4'hD: dpalu_pass = z || (n != v);
      4'hE: dpalu_pass = 1'b1;
      default: dpalu_pass = 1'b0;
    endcase
  endfunction : dpalu_pass

  // Opcodes that only set flags
  function automatic logic dpalu_is_test(input logic [3:0] o);
    dpalu_is_test = o inside {dpalu_pkg::OP_TAND, dpalu_pkg::OP_TXOR,
                              dpalu_pkg::OP_CMPS, dpalu_pkg::OP_CMPA};
  endfunction : dpalu_is_test

  // Opcodes of the arithmetic class
  function automatic logic dpalu_is_arith(input logic [3:0] o);
    dpalu_is_arith = o inside {dpalu_pkg::OP_SUB, dpalu_pkg::OP_RSUB,
                               dpalu_pkg::OP_ADD, dpalu_pkg::OP_ADC,
                               dpalu_pkg::OP_SBC, dpalu_pkg::OP_RSBC,
                               dpalu_pkg::OP_CMPS, dpalu_pkg::OP_CMPA};
  endfunction : dpalu_is_arith

  // --------------------------------------------------
  // Field extraction
  // --------------------------------------------------
  logic [3:0] f_cond;
  logic [1:0] f_cls;
  logic f_imm;
  logic [3:0] f_op;
  logic f_s;
  logic [3:0] f_rd;
  logic [7:0] f_shift;
  logic [3:0] f_rot;
  logic [7:0] f_byte;
  logic [3:0] flags;

  // Fixed instruction layout
  assign f_cond = instr_word[dpalu_pkg::COND_HI:dpalu_pkg::COND_LO];
  assign f_cls = instr_word[dpalu_pkg::CLS_HI:dpalu_pkg::CLS_LO];
  assign f_imm = instr_word[dpalu_pkg::IMM_BIT];
  assign f_op = instr_word[dpalu_pkg::OP_HI:dpalu_pkg::OP_LO];
  assign f_s = instr_word[dpalu_pkg::S_BIT];
  assign f_rd = instr_word[dpalu_pkg::RD_HI:dpalu_pkg::RD_LO];
  assign f_shift = instr_word[dpalu_pkg::SH_HI:dpalu_pkg::SH_LO];
  assign f_rot = instr_word[dpalu_pkg::ROT_HI:dpalu_pkg::ROT_LO];
  assign f_byte = instr_word[dpalu_pkg::BYTE_HI:dpalu_pkg::BYTE_LO];
  assign flags = st.psw[dpalu_pkg::FN:dpalu_pkg::FV];

  // --------------------------------------------------
  // Operands and adder
  // --------------------------------------------------
  logic exec;
  logic [31:0] imm_val;
  logic [31:0] op1;
  logic [31:0] op2;
  logic sh_c;
  logic [31:0] ax;
  logic [31:0] bx;
  logic cin;
  logic [32:0] sum;
  logic ovf;
  logic [31:0] res;
  logic arith;

  // Execute only a passing data-processing word
  assign exec = instr_valid && (f_cls == dpalu_pkg::CLS_DP)
                && dpalu_pass(f_cond, flags);
  // Byte rotated right by twice the field
  assign imm_val = ({24'h0, f_byte} >> {f_rot, 1'b0})
                 | ({24'h0, f_byte} << (6'h20 - {1'b0, f_rot, 1'b0}));
  assign op1 = first_operand;
  assign op2 = f_imm ? imm_val : shifted_operand;
  // Shifter carry; LEFT_LOGICAL_SHIFT 0 and unrotated immediates keep C
  always_comb begin
    if (f_imm) begin
      sh_c = (f_rot == dpalu_pkg::ROT_NONE) ? st.psw[dpalu_pkg::FC] : imm_val[31];
    end else begin
      sh_c = (f_shift == dpalu_pkg::SH_LSL0) ? st.psw[dpalu_pkg::FC] : shifter_carry;
    end
  end

  // Adder inputs per opcode
  always_comb begin
    ax = op1;
    bx = op2;
    cin = 1'b0;
    unique case (f_op)
      dpalu_pkg::OP_SUB, dpalu_pkg::OP_CMPS: begin
        bx = ~op2;
        cin = 1'b1;
      end
      dpalu_pkg::OP_RSUB: begin
        ax = op2;
        bx = ~op1;
        cin = 1'b1;
      end
      dpalu_pkg::OP_ADC: cin = st.psw[dpalu_pkg::FC];
      dpalu_pkg::OP_SBC: begin
        bx = ~op2;
        cin = st.psw[dpalu_pkg::FC];
      end
      dpalu_pkg::OP_RSBC: begin
        ax = op2;
        bx = ~op1;
        cin = st.psw[dpalu_pkg::FC];
      end
      default: cin = 1'b0;
    endcase
  end
  // Single 33-bit adder for both views
  assign sum = {1'b0, ax} + {1'b0, bx} + {32'h0, cin};
  assign ovf = (ax[31] == bx[31]) && (sum[31] != ax[31]);
  assign arith = dpalu_is_arith(f_op);

  // Result selection
  always_comb begin
    unique case (f_op)
      dpalu_pkg::OP_AND, dpalu_pkg::OP_TAND: res = op1 & op2;
      dpalu_pkg::OP_XOR, dpalu_pkg::OP_TXOR: res = op1 ^ op2;
      dpalu_pkg::OP_IOR: res = op1 | op2;
      dpalu_pkg::OP_MOVE: res = op2;
      dpalu_pkg::OP_BCLR: res = op1 & ~op2;
      dpalu_pkg::OP_MINV: res = ~op2;
      default: res = sum[31:0];
    endcase
  end

  // --------------------------------------------------
  // Next state
  // --------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.rvalid = 1'b0;
    next_st.dwe = 1'b0;
    next_st.pcwe = 1'b0;
    next_st.rest = 1'b0;
    next_st.fupd = 1'b0;
    next_st.rdata = 32'h0;
    // Software write first, hardware overrides
    if (reg_write && reg_addr == dpalu_pkg::RA_PSW) begin
      next_st.psw = reg_wdata;
    end
    if (exec) begin
      next_st.rvalid = 1'b1;
      next_st.res = res;
      next_st.didx = f_rd;
      next_st.cnt = st.cnt + 1'b1;
      next_st.dwe = !dpalu_is_test(f_op);
      next_st.pcwe = !dpalu_is_test(f_op) && (f_rd == dpalu_pkg::PC_IDX);
      if (f_s && f_rd == dpalu_pkg::PC_IDX) begin
        next_st.psw = saved_status_word;
        next_st.rest = 1'b1;
      end else if (f_s) begin
        // Flag update discards a same-cycle software write wholly
        next_st.psw = st.psw;
        next_st.fupd = 1'b1;
        next_st.psw[dpalu_pkg::FN] = res[31];
        next_st.psw[dpalu_pkg::FZ] = (res == 32'h0);
        next_st.psw[dpalu_pkg::FC] = arith ? sum[32] : sh_c;
        next_st.psw[dpalu_pkg::FV] = arith ? ovf : st.psw[dpalu_pkg::FV];
      end
    end
    // Register read, data next cycle
    if (reg_read) begin
      unique case (reg_addr)
        dpalu_pkg::RA_PSW: next_st.rdata = st.psw;
        dpalu_pkg::RA_RES: next_st.rdata = st.res;
        dpalu_pkg::RA_CNT: next_st.rdata = 32'(st.cnt);
        default: next_st.rdata = 32'h0;
      endcase
    end
  end

  // State register
  always_ff @(posedge clock) begin
    if (rst) begin
      st <= '{psw: dpalu_pkg::PSW_RST, default: '0};
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state flops
  assign reg_rdata = st.rdata;
  assign result_valid = st.rvalid;
  assign result_data = st.res;
  assign dest_write = st.dwe;
  assign dest_index = st.didx;
  assign pc_write = st.pcwe;
  assign status_restored = st.rest;
  assign program_status_word = st.psw;

  // --------------------------------------------------
  // Checks
  // --------------------------------------------------
  chk_pred_fail_idle: assert property (@(posedge clock) disable iff (rst)
    instr_valid && !dpalu_pass(f_cond, flags) && !reg_write
    |=> !result_valid && !dest_write && $stable(program_status_word))
    else $error("failed predicate had an effect");
  chk_test_no_write: assert property (@(posedge clock) disable iff (rst)
    exec && dpalu_is_test(f_op) |=> result_valid && !dest_write && !pc_write)
    else $error("test op wrote destination");
  chk_s_clear_keep: assert property (@(posedge clock) disable iff (rst)
    exec && !f_s && !reg_write |=> $stable(program_status_word))
    else $error("flags changed without update bit");
  chk_flag_nz_res: assert property (@(posedge clock) disable iff (rst)
    st.fupd |-> program_status_word[dpalu_pkg::FZ] == (result_data == 32'h0)
    && program_status_word[dpalu_pkg::FN] == result_data[31])
    else $error("zero or negative flag wrong");
  chk_logic_v_keep: assert property (@(posedge clock) disable iff (rst)
    exec && f_s && !arith && f_rd != dpalu_pkg::PC_IDX
    |=> program_status_word[dpalu_pkg::FV] == $past(st.psw[dpalu_pkg::FV]))
    else $error("logical op changed overflow");
  chk_move_reg_op: assert property (@(posedge clock) disable iff (rst)
    exec && !f_imm && f_op == dpalu_pkg::OP_MOVE
    |=> result_data == $past(shifted_operand))
    else $error("move did not pass shifted register");
  chk_pc_restore: assert property (@(posedge clock) disable iff (rst)
    exec && f_s && f_rd == dpalu_pkg::PC_IDX
    |=> status_restored && program_status_word == $past(saved_status_word))
    else $error("status word not restored");
  chk_sub_borrow: assert property (@(posedge clock) disable iff (rst)
    exec && f_s && f_op == dpalu_pkg::OP_SUB && f_rd != dpalu_pkg::PC_IDX
    |=> program_status_word[dpalu_pkg::FC]
        == ($past(op1) >= $past(op2)))
    else $error("subtract carry is not no-borrow");
  chk_add_result: assert property (@(posedge clock) disable iff (rst)
    exec && f_op == dpalu_pkg::OP_ADD
    |=> result_data == $past(op1) + $past(op2))
    else $error("add result wrong");
  chk_adc_result: assert property (@(posedge clock) disable iff (rst)
    exec && f_op == dpalu_pkg::OP_ADC
    |=> result_data == $past(op1) + $past(op2) + 32'($past(st.psw[dpalu_pkg::FC])))
    else $error("add with carry result wrong");
  chk_sbc_result: assert property (@(posedge clock) disable iff (rst)
    exec && f_op == dpalu_pkg::OP_SBC
    |=> result_data == $past(op1) - $past(op2) - 32'(!$past(st.psw[dpalu_pkg::FC])))
    else $error("subtract with carry result wrong");
  chk_rsub_result: assert property (@(posedge clock) disable iff (rst)
    exec && f_op == dpalu_pkg::OP_RSUB |=> result_data == $past(op2) - $past(op1))
    else $error("reverse subtract result wrong");

  // Field decode and refusal of other classes
  chk_dest_index: assert property (@(posedge clock) disable iff (rst)
    exec |=> result_valid && dest_index == $past(f_rd))
    else $error("destination index not taken from the word");
  chk_bad_class_idle: assert property (@(posedge clock) disable iff (rst)
    instr_valid && f_cls != dpalu_pkg::CLS_DP |=> !result_valid)
    else $error("other instruction class executed");

  // Logical results
  chk_and_result: assert property (@(posedge clock) disable iff (rst)
    exec && f_op == dpalu_pkg::OP_AND |=> result_data == ($past(op1) & $past(op2)))
    else $error("and result wrong");
  chk_ior_result: assert property (@(posedge clock) disable iff (rst)
    exec && f_op == dpalu_pkg::OP_IOR |=> result_data == ($past(op1) | $past(op2)))
    else $error("inclusive or result wrong");
  chk_bclr_result: assert property (@(posedge clock) disable iff (rst)
    exec && f_op == dpalu_pkg::OP_BCLR |=> result_data == ($past(op1) & ~$past(op2)))
    else $error("bit clear result wrong");
  chk_minv_result: assert property (@(posedge clock) disable iff (rst)
    exec && f_op == dpalu_pkg::OP_MINV |=> result_data == ~$past(op2))
    else $error("inverted move result wrong");
  chk_xor_first_op: assert property (@(posedge clock) disable iff (rst)
    exec && f_op == dpalu_pkg::OP_XOR
    |=> result_data == ($past(first_operand) ^ $past(op2)))
    else $error("first operand not from source register");

  // Arithmetic flags
  chk_add_carry: assert property (@(posedge clock) disable iff (rst)
    exec && f_s && f_op == dpalu_pkg::OP_ADD && f_rd != dpalu_pkg::PC_IDX
    |=> program_status_word[dpalu_pkg::FC]
        == (33'($past(op1)) + 33'($past(op2)) > 33'h0_FFFF_FFFF))
    else $error("add carry is not carry out");
  chk_add_ovf: assert property (@(posedge clock) disable iff (rst)
    exec && f_s && f_op == dpalu_pkg::OP_ADD && f_rd != dpalu_pkg::PC_IDX
    |=> program_status_word[dpalu_pkg::FV]
        == ($past(op1[31]) == $past(op2[31]) && result_data[31] != $past(op1[31])))
    else $error("add overflow wrong");
  chk_test_sets_flags: assert property (@(posedge clock) disable iff (rst)
    exec && f_s && dpalu_is_test(f_op) && f_rd != dpalu_pkg::PC_IDX |=> st.fupd)
    else $error("test op did not set flags");

  // Immediate operand and shifter carry
  chk_imm_rotate: assert property (@(posedge clock) disable iff (rst)
    exec && f_imm && f_op == dpalu_pkg::OP_MOVE
    |=> result_data == ((32'($past(f_byte)) >> (2 * $past(f_rot)))
        | (32'($past(f_byte)) << (32 - 2 * $past(f_rot)))))
    else $error("immediate not rotated by twice the field");
  chk_logic_c_shift: assert property (@(posedge clock) disable iff (rst)
    exec && f_s && !arith && !f_imm && f_shift != dpalu_pkg::SH_LSL0
    && f_rd != dpalu_pkg::PC_IDX
    |=> program_status_word[dpalu_pkg::FC] == $past(shifter_carry))
    else $error("logical carry not from shifter");
  chk_lsl0_c_keep: assert property (@(posedge clock) disable iff (rst)
    exec && f_s && !arith && !f_imm && f_shift == dpalu_pkg::SH_LSL0
    && f_rd != dpalu_pkg::PC_IDX
    |=> program_status_word[dpalu_pkg::FC] == $past(st.psw[dpalu_pkg::FC]))
    else $error("zero shift changed carry");

  // Destination 15 handling
  chk_pc_write: assert property (@(posedge clock) disable iff (rst)
    exec && !dpalu_is_test(f_op) && f_rd == dpalu_pkg::PC_IDX |=> pc_write && dest_write)
    else $error("result not sent to program counter");
  chk_pc_no_flags: assert property (@(posedge clock) disable iff (rst)
    exec && f_s && f_rd == dpalu_pkg::PC_IDX |=> !st.fupd)
    else $error("flags applied with destination 15");
endmodule : dpalu_core

// ==== inc/dpalu_pkg.sv ====
// Purpose: constants for the data-processing ALU
// Assumes: 32-bit instruction word, one clock
// Notes: flags sit in the top nibble of the status word
package dpalu_pkg;
  localparam int COND_HI = 31;
  localparam int COND_LO = 28;
  localparam int CLS_HI = 27;
  localparam int CLS_LO = 26;
  localparam int IMM_BIT = 25;
  localparam int OP_HI = 24;
  localparam int OP_LO = 21;
  localparam int S_BIT = 20;
  localparam int RN_HI = 19;
  localparam int RN_LO = 16;
  localparam int RD_HI = 15;
  localparam int RD_LO = 12;
  localparam int SH_HI = 11;
  localparam int SH_LO = 4;
  localparam int RM_HI = 3;
  localparam int RM_LO = 0;
  localparam int ROT_HI = 11;
  localparam int ROT_LO = 8;
  localparam int BYTE_HI = 7;
  localparam int BYTE_LO = 0;
  localparam int FN = 31;
  localparam int FZ = 30;
  localparam int FC = 29;
  localparam int FV = 28;
  localparam logic [1:0] CLS_DP = 2'h0;
  localparam logic [3:0] PC_IDX = 4'hF;
  localparam logic [7:0] SH_LSL0 = 8'h00;
  localparam logic [3:0] ROT_NONE = 4'h0;
  localparam logic [3:0] OP_AND = 4'h0;
  localparam logic [3:0] OP_XOR = 4'h1;
  localparam logic [3:0] OP_SUB = 4'h2;
  localparam logic [3:0] OP_RSUB = 4'h3;
  localparam logic [3:0] OP_ADD = 4'h4;
  localparam logic [3:0] OP_ADC = 4'h5;
  localparam logic [3:0] OP_SBC = 4'h6;
  localparam logic [3:0] OP_RSBC = 4'h7;
  localparam logic [3:0] OP_TAND = 4'h8;
  localparam logic [3:0] OP_TXOR = 4'h9;
  localparam logic [3:0] OP_CMPS = 4'hA;
  localparam logic [3:0] OP_CMPA = 4'hB;
  localparam logic [3:0] OP_IOR = 4'hC;
  localparam logic [3:0] OP_MOVE = 4'hD;
  localparam logic [3:0] OP_BCLR = 4'hE;
  localparam logic [3:0] OP_MINV = 4'hF;
  localparam logic [3:0] RA_PSW = 4'h0;
  localparam logic [3:0] RA_RES = 4'h4;
  localparam logic [3:0] RA_CNT = 4'h8;
  localparam logic [31:0] PSW_RST = 32'h0000_0000;
endpackage : dpalu_pkg

// ==== sim/dpalu_feed.sv ====
// Purpose: operand feed beside the ALU: register file and LEFT_LOGICAL_SHIFT shifter
// Assumes: register-form shifts are LEFT_LOGICAL_SHIFT by an immediate amount
// Notes: bench loads rf by hierarchical writes
`timescale 1ns/1ns
module dpalu_feed (
  input wire logic [31:0] instr_word,
  input wire logic old_carry,
  output logic [31:0] first_operand,
  output logic [31:0] shifted_operand,
  output logic shifter_carry
);
  logic [31:0] rf [16];
  logic [4:0] amt;
  logic [31:0] rm;
  // Operand select and shift, LEFT_LOGICAL_SHIFT 0 passes old carry
  always_comb begin
    amt = instr_word[11:7];
    rm = rf[instr_word[3:0]];
    first_operand = rf[instr_word[19:16]];
    shifted_operand = rm << amt;
    shifter_carry = (amt == 5'h00) ? old_carry : rm[6'h20 - {1'b0, amt}];
  end
endmodule : dpalu_feed

// ==== sim/tb.sv ====
// Purpose: self-checking bench for the data-processing ALU
// Assumes: feed model supplies operands and shifter carry
// Notes: flags are read from the status word port
`timescale 1ns/1ns
module tb;
  logic clock, rst, instr_valid, shifter_carry, reg_write, reg_read;
  logic [31:0] instr_word, first_operand, shifted_operand, saved_status_word;
  logic [31:0] reg_wdata, reg_rdata, result_data, program_status_word;
  logic [3:0] reg_addr, dest_index;
  logic result_valid, dest_write, pc_write, status_restored;
  int n_fail = 0;
  int compares = 0;
  int cycles = 0;
  dpalu_core u_dut (.clock(clock), .rst(rst), .instr_valid(instr_valid),
    .instr_word(instr_word), .first_operand(first_operand),
    .shifted_operand(shifted_operand), .shifter_carry(shifter_carry),
    .saved_status_word(saved_status_word), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .result_valid(result_valid), .result_data(result_data), .dest_write(dest_write),
    .dest_index(dest_index), .pc_write(pc_write), .status_restored(status_restored),
    .program_status_word(program_status_word));
  dpalu_feed u_feed (.instr_word(instr_word), .old_carry(program_status_word[29]),
    .first_operand(first_operand), .shifted_operand(shifted_operand),
    .shifter_carry(shifter_carry));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      test_done();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic run(input logic [31:0] w);
    @(posedge clock);
    instr_valid <= 1'b1;
    instr_word <= w;
    @(posedge clock);
    instr_valid <= 1'b0;
    #1;
  endtask : run
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask : rd
  function automatic logic [31:0] mk(input logic [3:0] cd, op, input logic im, s,
      input logic [3:0] rn, rd, input logic [11:0] o2);
    return {cd, 2'b00, im, op, s, rn, rd, o2};
  endfunction : mk
  // Predicate over NZCV, 1111 never passes
  function automatic logic pass(input logic [3:0] cd, input logic [3:0] f);
    logic r;
    case (cd[3:1])
      3'h0: r = f[2];
      3'h1: r = f[1];
      3'h2: r = f[3];
      3'h3: r = f[0];
      3'h4: r = f[1] & ~f[2];
      3'h5: r = f[3] == f[0];
      3'h6: r = ~f[2] & (f[3] == f[0]);
      default: r = 1'b1;
    endcase
    return (cd == 4'hF) ? 1'b0 : (cd[0] & (cd != 4'hE)) ? ~r : r;
  endfunction : pass
  // Reference result as {arith, carry, overflow, result}
  function automatic logic [34:0] alu(input logic [3:0] op, input logic [31:0] a, b,
      input logic c);
    logic [31:0] x, y, r;
    logic [32:0] s;
    logic ci, ar;
    x = (op == 4'h3 || op == 4'h7) ? b : a;
    y = (op == 4'h3 || op == 4'h7) ? ~a : (op == 4'h4 || op == 4'h5 || op == 4'hB) ? b : ~b;
    ci = (op == 4'h5 || op == 4'h6 || op == 4'h7) ? c : (op == 4'h4 || op == 4'hB) ? 1'b0 : 1'b1;
    ar = (op[3:1] == 3'h1) || (op[3:1] == 3'h2) || (op[3:1] == 3'h3) || (op[3:1] == 3'h5);
    s = {1'b0, x} + {1'b0, y} + {32'h0, ci};
    case (op)
      4'h0, 4'h8: r = a & b;
      4'h1, 4'h9: r = a ^ b;
      4'hC: r = a | b;
      4'hD: r = b;
      4'hE: r = a & ~b;
      4'hF: r = ~b;
      default: r = s[31:0];
    endcase
    return {ar, s[32], (x[31] == y[31]) && (s[31] != x[31]), r};
  endfunction : alu
  task automatic t_regs();
    rd(4'h0, 32'h0);
    rd(4'h8, 32'h0);
    run(mk(4'hE, 4'hD, 1'b1, 1'b0, 4'h0, 4'h7, 12'h05A));
    chk(32'(dest_index), 32'h7);
    rd(4'h4, 32'h5A);
    rd(4'h8, 32'h1);
    wr(4'h4, 32'hFFFF_FFFF);
    rd(4'h4, 32'h5A);
    wr(4'h0, 32'hF000_0000);
    rd(4'h0, 32'hF000_0000);
    rd(4'hC, 32'h0);
  endtask : t_regs
  task automatic t_ops();
    logic [34:0] e;
    logic [3:0] f;
    u_feed.rf[2] = 32'h8000_0001;
    u_feed.rf[3] = 32'hC000_0004;
    for (int op = 0; op < 16; op++) begin
      f = 4'(op) ^ 4'h5;
      wr(4'h0, {f, 28'h0});
      e = alu(4'(op), 32'h8000_0001, 32'h8000_0008, f[1]);
      run(mk(4'hE, 4'(op), 1'b0, 1'b1, 4'h2, 4'h1, 12'h083));
      chk(32'(dest_write), 32'((op >> 2) != 2));
      if ((op >> 2) != 2) chk(result_data, e[31:0]);
      chk(32'(program_status_word[31:28]), 32'({e[31], e[31:0] == 32'h0,
        e[34] ? e[33] : 1'b1, e[34] ? e[32] : f[0]}));
    end
  endtask : t_ops
  task automatic t_cond();
    for (int f = 0; f < 16; f++) begin
      wr(4'h0, {4'(f), 28'h0});
      for (int cd = 0; cd < 16; cd++) begin
        run(mk(4'(cd), 4'hD, 1'b1, 1'b0, 4'h0, 4'h2, 12'h0FF));
        chk(32'(result_valid), 32'(pass(4'(cd), 4'(f))));
        chk(program_status_word, {4'(f), 28'h0});
      end
    end
  endtask : t_cond
  task automatic t_imm();
    logic [31:0] x;
    for (int r = 0; r < 16; r++) begin
      wr(4'h0, 32'h3000_0000);
      x = (32'h81 >> (2 * r)) | (32'h81 << (32 - 2 * r));
      run(mk(4'hE, 4'hD, 1'b1, 1'b1, 4'h0, 4'h5, {4'(r), 8'h81}));
      chk(result_data, x);
      chk(32'(program_status_word[31:28]),
        32'({x[31], 1'b0, (r == 0) ? 1'b1 : x[31], 1'b1}));
    end
    u_feed.rf[6] = 32'h10;
    wr(4'h0, 32'h2000_0000);
    run(mk(4'hE, 4'hD, 1'b0, 1'b1, 4'h0, 4'h5, 12'h006));
    chk(result_data, 32'h10);
    chk(program_status_word, 32'h2000_0000);
  endtask : t_imm
  task automatic t_pc();
    wr(4'h0, 32'h0);
    run(mk(4'hE, 4'h4, 1'b0, 1'b1, 4'h2, 4'hF, 12'h083));
    chk(32'({pc_write, status_restored}), 32'h3);
    chk(program_status_word, 32'h9000_0000);
    chk(result_data, 32'h9);
    wr(4'h0, 32'h0);
    run(mk(4'hE, 4'h4, 1'b0, 1'b0, 4'h2, 4'hF, 12'h083));
    chk(32'({pc_write, status_restored}), 32'h2);
    chk(program_status_word, 32'h0);
    run({4'hE, 2'b01, 26'h0});
    chk(32'(result_valid), 32'h0);
  endtask : t_pc
  task automatic test_done();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  initial begin
    rst = 1'b1;
    instr_valid = 1'b0;
    instr_word = 32'h0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    saved_status_word = 32'h9000_0000;
    u_feed.rf[0] = 32'h0;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    t_regs();
    $display("registers done");
    t_ops();
    $display("operations done");
    t_cond();
    $display("predicates done");
    t_imm();
    $display("immediates done");
    t_pc();
    $display("destination 15 done");
    test_done();
  end
endmodule : tb
